// *** rtl/tmr16_pkg.sv ***
package tmr16_pkg;

  // register map, byte addresses on the 32-bit bus
  localparam int          ADDR_W                 = 6;
  localparam logic [5:0]  TIMER2_CONTROL_OFF     = 6'h00;
  localparam logic [5:0]  MATCH_LOW_OFF          = 6'h04;
  localparam logic [5:0]  MATCH_HIGH_OFF         = 6'h08;
  localparam logic [5:0]  TIMER2_MATCH_VALUE_OFF = 6'h0C;
  localparam logic [5:0]  CONFIG_OFF             = 6'h10;
  localparam logic [5:0]  STATUS_OFF             = 6'h14;
  localparam logic [5:0]  MASK_OFF               = 6'h18;
  localparam logic [5:0]  COUNT_OFF              = 6'h1C;

  // control byte fields
  localparam int          RUN_BIT                = 5;
  localparam int          SRC_LSB                = 2;
  localparam int          OPSEL_BIT              = 0;
  localparam logic [7:0]  CONTROL_RST            = 8'h00;
  localparam logic [7:0]  CONTROL_RD_MASK        = 8'h3D;

  // count source codes
  localparam logic [2:0]  SRC_TAP_A              = 3'h0;
  localparam logic [2:0]  SRC_TAP_B              = 3'h1;
  localparam logic [2:0]  SRC_TAP_C              = 3'h2;
  localparam logic [2:0]  SRC_TAP_D              = 3'h3;
  localparam logic [2:0]  SRC_HF                 = 3'h4;
  localparam logic [2:0]  SRC_LF                 = 3'h5;
  localparam logic [2:0]  SRC_RESERVED           = 3'h6;
  localparam logic [2:0]  SRC_EXT                = 3'h7;

  // system operating modes as driven on sys_mode
  localparam logic [1:0]  MODE_NORMAL            = 2'h0;
  localparam logic [1:0]  MODE_LOW_SPEED_ONE     = 2'h1;
  localparam logic [1:0]  MODE_LOW_SPEED_TWO     = 2'h2;
  localparam logic [1:0]  MODE_SLEEP             = 2'h3;

  // prescaler taps: log2 of the division
  localparam int          FC_TAP_N               = 4;
  localparam int          FS_TAP_N               = 2;
  localparam int          FC_DIV_W               = 23;
  localparam int          FS_DIV_W               = 15;
  localparam int          FC_TAPS [FC_TAP_N]     = '{23, 13, 8, 3};
  localparam int          FS_TAPS [FS_TAP_N]     = '{15, 5};

  localparam logic [15:0] MATCH_RST              = 16'hFFFF;
  localparam logic [15:0] CMP_MASK_FULL          = 16'hFFFF;
  localparam logic [15:0] CMP_MASK_UPPER         = 16'hF800;
  localparam int          STAT_MATCH_BIT         = 0;
  localparam logic [1:0]  RESP_OKAY              = 2'h0;
  localparam logic [1:0]  RESP_SLVERR            = 2'h2;

endpackage

// *** rtl/tmr16_prescaler.sv ***
`timescale 1ns/1ns
module tmr16_prescaler
  import tmr16_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                low_freq_tick,
  output logic [FC_TAP_N-1:0]      fc_ticks,
  output logic [FS_TAP_N-1:0]      fs_ticks
);

  logic [FC_DIV_W-1:0] fc_div;
  logic [FS_DIV_W-1:0] fs_div;
  logic [FC_DIV_W-1:0] next_fc_div;
  logic [FS_DIV_W-1:0] next_fs_div;
  logic [FC_TAP_N-1:0] next_fc_ticks;
  logic [FS_TAP_N-1:0] next_fs_ticks;

  // free running so taps stay phase-aligned across timer restarts
  always_comb begin
    next_fc_div = fc_div + {{(FC_DIV_W-1){1'b0}}, 1'b1};
    next_fs_div = low_freq_tick ? fs_div + {{(FS_DIV_W-1){1'b0}}, 1'b1} : fs_div;
  end

  genvar i;
  generate
    for (i = 0; i < FC_TAP_N; i++) begin : g_fc
      assign next_fc_ticks[i] = &fc_div[FC_TAPS[i]-1:0];
    end
    for (i = 0; i < FS_TAP_N; i++) begin : g_fs
      assign next_fs_ticks[i] = low_freq_tick & (&fs_div[FS_TAPS[i]-1:0]);
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fc_div   <= '0;
      fs_div   <= '0;
      fc_ticks <= '0;
      fs_ticks <= '0;
    end else begin
      fc_div   <= next_fc_div;
      fs_div   <= next_fs_div;
      fc_ticks <= next_fc_ticks;
      fs_ticks <= next_fs_ticks;
    end
  end

endmodule

// *** rtl/tmr16_match_stage.sv ***
`timescale 1ns/1ns
module tmr16_match_stage
  import tmr16_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                low_we,
  input  wire logic                high_we,
  input  wire logic [7:0]          wr_byte,
  input  wire logic                high_only_ok,
  output logic [15:0]              match_value
);

  logic [7:0]  low_pending;
  logic        low_held;
  logic [7:0]  next_low_pending;
  logic        next_low_held;
  logic [15:0] next_match_value;

  always_comb begin
    next_low_pending = low_pending;
    next_low_held    = low_held;
    next_match_value = match_value;
    // [RULE_04] low byte staged only
    if (low_we) begin
      next_low_pending = wr_byte;
      next_low_held    = 1'b1;
    end
    if (high_we) begin
      // [RULE_05] both bytes commit together
      if (low_held) begin
        next_match_value = {wr_byte, low_pending};
        next_low_held    = 1'b0;
      // [RULE_13] high byte alone suffices
      end else if (high_only_ok) begin
        next_match_value = {wr_byte, match_value[7:0]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_pending <= 8'h00;
      low_held    <= 1'b0;
      match_value <= MATCH_RST;
    end else begin
      low_pending <= next_low_pending;
      low_held    <= next_low_held;
      match_value <= next_match_value;
    end
  end

endmodule

// *** rtl/tmr16_top.sv ***
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Operation
// [RULE_01] Run bit low stops and zeroes the counter; high counts from zero.
// [RULE_02] Three-bit source field picks prescaler tap, low-frequency clock or pin.
// [RULE_03] Operation bit zero is timer/event counting, one is window counting.
// [RULE_04] Match is written low byte then high byte; lone byte writes ignored. Code commits a lone high byte in high-frequency low-speed-two timer mode.
// [RULE_05] Comparator keeps old match until the high byte completes the pair.
// [RULE_06] Software changes mode and source only while run bit is zero.
// [RULE_07] Software loads match above one; upper five bits above one for warm-up.
// [RULE_08] Control bits 7, 6 and 1 carry no defined read data.
// [RULE_09] High-frequency source code 100 works only in timer mode, low-speed two.
// [RULE_10] Stop mode entry clears the run bit; software restarts afterwards.
// [RULE_11] Timer mode on fast or slow clock can time oscillator warm-up.
// [RULE_12] Timer counts internal ticks; match raises interrupt, clears, keeps counting.
// [RULE_13] High-frequency source in low-speed two compares only the upper five bits.
// [RULE_14] Event counting increments on each rising edge of the input pin.
// [RULE_15] Event match is checked and signalled on the pin's falling edge.
// [RULE_16] Pin high and low levels each last at least two machine cycles.
// [RULE_17] Window mode counts internal ticks only while pin high; match clears.
// [RULE_18] Sixteen-bit counter; match interrupt is a one-cycle pulse per match.
module tmr16_top
  import tmr16_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                count_input_pin,
  input  wire logic                low_freq_tick,
  input  wire logic [1:0]          sys_mode,
  input  wire logic                stop_enter,
  output logic                     match_interrupt,
  output logic                     irq
);

  // bus state
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              next_aw_held;
  logic [ADDR_W-1:0] next_aw_addr_q;
  logic              next_w_held;
  logic [31:0]       next_w_data_q;
  logic [3:0]        next_w_strb_q;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic              rd_hit;

  // block state
  logic [7:0]        control_byte;
  logic              prescaler_source_select;
  logic [7:0]        status;
  logic [7:0]        mask;
  logic [15:0]       count;
  logic              pin_q;
  logic [7:0]        next_control_byte;
  logic              next_prescaler_source_select;
  logic [7:0]        next_status;
  logic [7:0]        next_mask;
  logic [15:0]       next_count;
  logic              next_pin_q;
  logic              next_match_interrupt;
  logic              next_irq;

  logic              ctrl_we;
  logic              low_we;
  logic              high_we;
  logic              cfg_we;
  logic              mask_we;
  logic              status_rd;
  logic              run_control_bit;
  logic [2:0]        count_source_select;
  logic              operation_select_bit;
  logic              low_speed;
  logic              hf_low_speed_mode_two;
  logic              int_tick;
  logic              pin_rise;
  logic              pin_fall;
  logic [15:0]       count_inc;
  logic [15:0]       cmp_mask;
  logic [15:0]       match_value;
  logic [FC_TAP_N-1:0] fc_ticks;
  logic [FS_TAP_N-1:0] fs_ticks;

  tmr16_prescaler u_prescaler (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .low_freq_tick (low_freq_tick),
    .fc_ticks      (fc_ticks),
    .fs_ticks      (fs_ticks)
  );

  tmr16_match_stage u_match (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .low_we       (low_we),
    .high_we      (high_we),
    .wr_byte      (wr_data[7:0]),
    .high_only_ok (hf_low_speed_mode_two),
    .match_value  (match_value)
  );

  assign run_control_bit      = control_byte[RUN_BIT];
  assign count_source_select  = control_byte[SRC_LSB +: 3];
  assign operation_select_bit = control_byte[OPSEL_BIT];

  // AXI4-Lite slave: address and data in either order, one response each
  always_comb begin
    aw_hs    = s_axi_awvalid & s_axi_awready;
    w_hs     = s_axi_wvalid & s_axi_wready;
    ar_hs    = s_axi_arvalid & s_axi_arready;
    wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
    wr_data  = w_held ? w_data_q : s_axi_wdata;
    wr_strb  = w_held ? w_strb_q : s_axi_wstrb;
    do_write = (aw_held | aw_hs) & (w_held | w_hs) & ~s_axi_bvalid;
    next_aw_held   = (aw_held | aw_hs) & ~do_write;
    next_w_held    = (w_held | w_hs) & ~do_write;
    next_aw_addr_q = aw_hs ? s_axi_awaddr : aw_addr_q;
    next_w_data_q  = w_hs ? s_axi_wdata : w_data_q;
    next_w_strb_q  = w_hs ? s_axi_wstrb : w_strb_q;
    wr_hit = (wr_addr[ADDR_W-1:2] <= COUNT_OFF[ADDR_W-1:2]);
    rd_hit = (s_axi_araddr[ADDR_W-1:2] <= COUNT_OFF[ADDR_W-1:2]);
    next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);
    next_bresp   = do_write ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp;
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
    next_rvalid  = ar_hs | (s_axi_rvalid & ~s_axi_rready);
    next_arready = ~next_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (ar_hs) begin
      next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        // [RULE_08] undefined bits read zero
        TIMER2_CONTROL_OFF:     next_rdata = {24'h000000, control_byte & CONTROL_RD_MASK};
        TIMER2_MATCH_VALUE_OFF: next_rdata = {16'h0000, match_value};
        CONFIG_OFF:             next_rdata = {31'h00000000, prescaler_source_select};
        STATUS_OFF:             next_rdata = {24'h000000, status};
        MASK_OFF:               next_rdata = {24'h000000, mask};
        COUNT_OFF:              next_rdata = {16'h0000, count};
        default:                next_rdata = 32'h00000000;
      endcase
    end
    // byte-wide registers take lane 0 only
    ctrl_we   = do_write & wr_strb[0] & (wr_addr == TIMER2_CONTROL_OFF);
    low_we    = do_write & wr_strb[0] & (wr_addr == MATCH_LOW_OFF);
    high_we   = do_write & wr_strb[0] & (wr_addr == MATCH_HIGH_OFF);
    cfg_we    = do_write & wr_strb[0] & (wr_addr == CONFIG_OFF);
    mask_we   = do_write & wr_strb[0] & (wr_addr == MASK_OFF);
    status_rd = ar_hs & ({s_axi_araddr[ADDR_W-1:2], 2'b00} == STATUS_OFF);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held       <= 1'b0;
      aw_addr_q     <= '0;
      w_held        <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      aw_addr_q     <= next_aw_addr_q;
      w_held        <= next_w_held;
      w_data_q      <= next_w_data_q;
      w_strb_q      <= next_w_strb_q;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // control and configuration registers
  always_comb begin
    next_control_byte            = control_byte;
    next_prescaler_source_select = prescaler_source_select;
    next_mask                    = mask;
    // mode and source not locked while running; software keeps them still
    // [RULE_06] relies on software order
    if (ctrl_we) begin
      next_control_byte = wr_data[7:0];
    end
    // [RULE_10] stop entry drops run
    if (stop_enter) begin
      next_control_byte[RUN_BIT] = 1'b0;
    end
    if (cfg_we) begin
      next_prescaler_source_select = wr_data[0];
    end
    if (mask_we) begin
      next_mask = wr_data[7:0];
    end
  end

  // count source selection
  always_comb begin
    low_speed = (sys_mode != MODE_NORMAL);
    // [RULE_09] fast clock only timer, low-speed two
    hf_low_speed_mode_two  = (sys_mode == MODE_LOW_SPEED_TWO) & ~operation_select_bit & (count_source_select == SRC_HF);
    // [RULE_13] upper five bits compared
    cmp_mask  = hf_low_speed_mode_two ? CMP_MASK_UPPER : CMP_MASK_FULL;
    int_tick  = 1'b0;
    // [RULE_02] source tap mux
    unique case (count_source_select)
      SRC_TAP_A:    int_tick = (low_speed | prescaler_source_select) ? fs_ticks[0] : fc_ticks[0];
      SRC_TAP_B:    int_tick = (low_speed | prescaler_source_select) ? fs_ticks[1] : fc_ticks[1];
      SRC_TAP_C:    int_tick = ~low_speed & fc_ticks[2];
      SRC_TAP_D:    int_tick = ~low_speed & fc_ticks[3];
      // [RULE_11] fast clock times warm-up
      SRC_HF:       int_tick = hf_low_speed_mode_two;
      SRC_LF:       int_tick = ~low_speed & low_freq_tick;
      SRC_RESERVED: int_tick = 1'b0;
      SRC_EXT:      int_tick = 1'b0;
    endcase
    // [RULE_16] edges valid given wide pulses
    pin_rise  = count_input_pin & ~pin_q;
    pin_fall  = ~count_input_pin & pin_q;
    count_inc = count + 16'h0001;
  end

  // up-counter and match
  always_comb begin
    next_count           = count;
    next_match_interrupt = 1'b0;
    next_pin_q           = count_input_pin;
    // [RULE_01] stopped means cleared
    if (!run_control_bit) begin
      next_count = 16'h0000;
    // [RULE_03] window operation
    end else if (operation_select_bit) begin
      // [RULE_17] gated by pin high
      if (int_tick && count_input_pin) begin
        if (count_inc == match_value) begin
          next_count           = 16'h0000;
          next_match_interrupt = 1'b1;
        end else begin
          next_count = count_inc;
        end
      end
    end else if (count_source_select == SRC_EXT) begin
      // [RULE_14] count on rising edge
      if (pin_rise) begin
        next_count = count_inc;
      // [RULE_15] match on falling edge
      end else if (pin_fall && count == match_value) begin
        next_count           = 16'h0000;
        next_match_interrupt = 1'b1;
      end
    // [RULE_12] timer count and match
    end else if (int_tick) begin
      if ((count_inc & cmp_mask) == (match_value & cmp_mask)) begin
        next_count           = 16'h0000;
        next_match_interrupt = 1'b1;
      end else begin
        next_count = count_inc;
      end
    end
  end

  // sticky status, cleared by reading it; a new match wins over the clear
  always_comb begin
    next_status = status_rd ? 8'h00 : status;
    // [RULE_18] one pulse per match
    if (next_match_interrupt) begin
      next_status[STAT_MATCH_BIT] = 1'b1;
    end
    next_irq = |(status & mask);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      control_byte            <= CONTROL_RST;
      prescaler_source_select <= 1'b0;
      mask                    <= 8'h00;
      status                  <= 8'h00;
      count                   <= 16'h0000;
      pin_q                   <= 1'b0;
      match_interrupt         <= 1'b0;
      irq                     <= 1'b0;
    end else begin
      control_byte            <= next_control_byte;
      prescaler_source_select <= next_prescaler_source_select;
      mask                    <= next_mask;
      status                  <= next_status;
      count                   <= next_count;
      pin_q                   <= next_pin_q;
      match_interrupt         <= next_match_interrupt;
      irq                     <= next_irq;
    end
  end

endmodule

// *** bench/tmr16_sva.sv ***
`timescale 1ns/1ns
module tmr16_sva
  import tmr16_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              stop_enter,
  input wire logic              match_interrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  pulse_single_a:
    assert property (match_interrupt |=> !match_interrupt) else $error("match pulse too long");
  stop_quiet_a:
    assert property (stop_enter |-> ##2 !match_interrupt [*3]) else $error("match after stop");
  ctrl_bits_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == TIMER2_CONTROL_OFF
      |=> s_axi_rdata[7:6] == 2'h0 && !s_axi_rdata[1]) else $error("control undefined bits set");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("no write answer");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
  bad_write_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr[5] && s_axi_wvalid && s_axi_wready
      |=> s_axi_bresp == RESP_SLVERR) else $error("unmapped write not refused");
  bad_read_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[5]
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  busy_refuse_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
endmodule

// *** bench/tmr16_pin_src.sv ***
`timescale 1ns/1ns
module tmr16_pin_src (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic       hold,
  input  wire logic [7:0] n,
  output logic            pin,
  output logic            busy
);
  logic [7:0] left;
  logic [2:0] ph;
  logic       q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      left <= 8'h00;
      ph <= 3'h0;
      q <= 1'b0;
    end else if (go) begin
      left <= n;
      ph <= 3'h0;
    end else if (left != 8'h00) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        q <= !q;
        if (q) left <= left - 8'h01;
      end
    end
  end
  // pin low between pulses unless hold drives it high
  assign pin = q | hold;
  assign busy = left != 8'h00;
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb
  import tmr16_pkg::*;
;
  logic              core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic              s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, count_input_pin, low_freq_tick, stop_enter, match_interrupt;
  logic              irq, go, hold, busy;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, sys_mode, rs;
  logic [7:0]        np;
  int                fail_count, comparisons, cyc, n;

  tmr16_top u_dut (.*);
  tmr16_pin_src u_src (.core_clk(core_clk), .rstn(rstn), .go(go), .hold(hold), .n(np),
    .pin(count_input_pin), .busy(busy));

  always #5 core_clk = ~core_clk;

  task report_and_stop;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, whole run is well under this
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // no local limit: only the cycle guard ends a wait on the bus
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rdr(input logic [5:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task wait_mi;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (match_interrupt !== 1'b1 && n < 5000);
  endtask

  // match above one keeps the comparator meaningful
  task set_match(input logic [15:0] v);
    wr(MATCH_LOW_OFF, {24'h0, v[7:0]});
    wr(MATCH_HIGH_OFF, {24'h0, v[15:8]});
  endtask

  task t_regs;
    rdr(TIMER2_CONTROL_OFF);
    chk(rd, 32'h0, "control reset");
    rdr(TIMER2_MATCH_VALUE_OFF);
    chk(rd, {16'h0, MATCH_RST}, "match reset");
    wr(6'h20, 32'h1);
    chk(rs, RESP_SLVERR, "unmapped write");
    rdr(6'h3C);
    chk(rs, RESP_SLVERR, "unmapped read");
    wr(TIMER2_CONTROL_OFF, 32'hDF);
    rdr(TIMER2_CONTROL_OFF);
    chk(rd, 32'h1D, "control readback");
    for (int s = 0; s < 8; s++) begin
      wr(TIMER2_CONTROL_OFF, 32'(s) << 2);
      rdr(TIMER2_CONTROL_OFF);
      chk(rd, 32'(s) << 2, "source field");
    end
  endtask

  task t_match;
    wr(MATCH_HIGH_OFF, 32'h12);
    rdr(TIMER2_MATCH_VALUE_OFF);
    chk(rd, 32'hFFFF, "lone high byte");
    wr(MATCH_LOW_OFF, 32'h34);
    rdr(TIMER2_MATCH_VALUE_OFF);
    chk(rd, 32'hFFFF, "low byte pending");
    wr(MATCH_HIGH_OFF, 32'h12);
    rdr(TIMER2_MATCH_VALUE_OFF);
    chk(rd, 32'h1234, "pair commit");
  endtask

  task t_timer;
    set_match(16'h0003);
    wr(TIMER2_CONTROL_OFF, 32'h2C);
    wait_mi;
    wait_mi;
    chk(n, 24, "timer period");
    chk(irq, 0, "masked irq");
    wr(MASK_OFF, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1, "unmasked irq");
    stop_enter <= 1'b1;
    @(posedge core_clk);
    stop_enter <= 1'b0;
    rdr(TIMER2_CONTROL_OFF);
    chk(rd, 32'h0C, "run cleared");
    rdr(COUNT_OFF);
    chk(rd, 32'h0, "count zeroed");
    rdr(STATUS_OFF);
    chk(rd, 32'h1, "status sticky");
    rdr(STATUS_OFF);
    chk(rd, 32'h0, "status cleared by read");
    repeat (3) @(posedge core_clk);
    chk(irq, 0, "irq after clear");
  endtask

  task t_hf;
    wr(TIMER2_CONTROL_OFF, 32'h30);
    repeat (20) @(posedge core_clk);
    rdr(COUNT_OFF);
    chk(rd, 32'h0, "fast source idle");
    wr(TIMER2_CONTROL_OFF, 32'h10);
    sys_mode <= MODE_LOW_SPEED_TWO;
    wr(MATCH_HIGH_OFF, 32'h08);
    rdr(TIMER2_MATCH_VALUE_OFF);
    chk(rd, 32'h0803, "high only");
    wr(TIMER2_CONTROL_OFF, 32'h30);
    wait_mi;
    wait_mi;
    chk(n, 2048, "upper five bits");
    wr(TIMER2_CONTROL_OFF, 32'h10);
    sys_mode <= MODE_NORMAL;
  endtask

  task t_lf;
    wr(TIMER2_CONTROL_OFF, 32'h14);
    wr(TIMER2_CONTROL_OFF, 32'h34);
    repeat (2) begin
      low_freq_tick <= 1'b1;
      @(posedge core_clk);
      low_freq_tick <= 1'b0;
      @(posedge core_clk);
    end
    rdr(COUNT_OFF);
    chk(rd, 32'h2, "slow clock source");
    wr(TIMER2_CONTROL_OFF, 32'h14);
  endtask

  task pulses(input logic [7:0] c);
    @(posedge core_clk);
    go <= 1'b1;
    np <= c;
    @(posedge core_clk);
    go <= 1'b0;
  endtask

  task t_event;
    set_match(16'h0003);
    wr(TIMER2_CONTROL_OFF, 32'h3C);
    pulses(8'h03);
    wait_mi;
    chk(count_input_pin, 0, "match on fall");
    chk(n > 44 && n < 54, 1, "event timing");
    pulses(8'h01);
    repeat (20) @(posedge core_clk);
    rdr(COUNT_OFF);
    chk(rd, 32'h1, "resumed count");
    wr(TIMER2_CONTROL_OFF, 32'h0D);
    wr(TIMER2_CONTROL_OFF, 32'h2D);
    repeat (40) @(posedge core_clk);
    rdr(COUNT_OFF);
    chk(rd, 32'h0, "window closed");
    hold <= 1'b1;
    wait_mi;
    chk(n < 40, 1, "window match");
    hold <= 1'b0;
    wr(TIMER2_CONTROL_OFF, 32'h0D);
  endtask

  initial begin
    core_clk = 0;
    rstn = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {low_freq_tick, stop_enter, go, hold, np, sys_mode} = '0;
    {fail_count, comparisons, cyc} = '0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_regs;
    t_match;
    t_timer;
    t_hf;
    t_lf;
    t_event;
    report_and_stop;
  end
endmodule

bind tmr16_top tmr16_sva u_sva (.*);
